// [rtl/scrpc_pkg.sv]
package scrpc_pkg;

    localparam int NPER = 8;
    localparam int NINT = 7;
    localparam int NRST = 6;

    localparam logic [7:0] A_CLKCFG   = 8'h00;
    localparam logic [7:0] A_DSCLKCFG = 8'h04;
    localparam logic [7:0] A_PERIPH   = 8'h08;
    localparam logic [7:0] A_SLPEN    = 8'h0C;
    localparam logic [7:0] A_DSLPEN   = 8'h10;
    localparam logic [7:0] A_PERRST   = 8'h14;
    localparam logic [7:0] A_RIS      = 8'h18;
    localparam logic [7:0] A_IMASK    = 8'h1C;
    localparam logic [7:0] A_MIS      = 8'h20;
    localparam logic [7:0] A_RESC     = 8'h24;
    localparam logic [7:0] A_LDO      = 8'h28;
    localparam logic [7:0] A_MODE     = 8'h2C;
    localparam logic [7:0] A_SWRST    = 8'h30;
    localparam logic [7:0] A_PRESENT  = 8'h34;
    localparam logic [7:0] A_MEMSIZE  = 8'h38;
    localparam logic [7:0] A_PINS     = 8'h3C;
    localparam logic [7:0] A_READY    = 8'h40;
    localparam logic [7:0] A_PIOSCSEL = 8'h44;
    localparam logic [7:0] A_RSTCFG   = 8'h48;

    localparam logic [31:0] SWRST_KEY = 32'h0000_0001;

    // Oscillator codes.
    localparam logic [2:0] OSC_MAIN  = 3'h0;
    localparam logic [2:0] OSC_INT   = 3'h1;
    localparam logic [2:0] OSC_PRECISION_INTERNAL_OSC = 3'h2;
    localparam logic [2:0] OSC_EXT   = 3'h3;
    localparam logic [2:0] OSC_PLL   = 3'h4;

    // LDO level code: 0 = 2.25 V ... 10 = 2.75 V in 50 mV steps, 5 = 2.5 V.
    localparam logic [3:0] LDO_MIN = 4'h0;
    localparam logic [3:0] LDO_MAX = 4'hA;
    localparam logic [3:0] LDO_DEF = 4'h5;

    // Interrupt bit positions.
    localparam int I_PLLLOCK = 0;
    localparam int I_CURLIM  = 1;
    localparam int I_IOSCF   = 2;
    localparam int I_MOSCF   = 3;
    localparam int I_BOR     = 4;
    localparam int I_LDOLOW  = 5;
    localparam int I_PLLF    = 6;

    // Reset cause bit positions.
    localparam int R_BOR  = 0;
    localparam int R_LDO  = 1;
    localparam int R_EXT  = 2;
    localparam int R_SW   = 3;
    localparam int R_WDT  = 4;
    localparam int R_MOSC = 5;

    // Arbitrary neutral information values.
    localparam logic [NPER-1:0] PRESENT_DEF = 8'hFF;
    localparam logic [31:0]     MEMSIZE_DEF = 32'h0010_0020;
    localparam logic [31:0]     PINS_DEF    = 32'h0000_00FF;

    typedef enum logic [1:0] {
        SCRPC_RUN,
        SCRPC_SLEEP,
        SCRPC_DEEP
    } scrpc_mode_type;

    typedef struct packed {
        logic [2:0] pll_ref;
        logic [2:0] sys_src;
    } scrpc_clkcfg_type;

    typedef struct packed {
        logic [NINT-1:0] ev;
    } scrpc_irqev_type;

endpackage

// [rtl/scrpc_sync.sv]
`timescale 1ns/1ps
module scrpc_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         resetn,
    input  wire logic         ce,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s1_d;
    logic [W-1:0] s2_d;

    always_comb begin
        s1_d = ce ? din : s1_q;
        s2_d = ce ? s1_q : s2_q;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s1_q <= '0;
            s2_q <= '0;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
        end
    end

    assign dout = s2_q;
endmodule // scrpc_sync

// [rtl/scrpc_top.sv]
// Overview of operation
// - Sleep keeps clock configuration, stops core clock and execution.
// - Deep sleep may change device clock, stops core clock and execution.
// - Deep sleep bypasses the PLL: a deep-sleep PLL selection runs from the main oscillator instead.
// - Any interrupt wakes to run; sleep entered only on software request.
// - Supply, LDO, external, software, watchdog, main oscillator faults reset the device.
// - Every reset cause is recorded until software clears it and is readable; each cause's recording configurable.
// - Each peripheral has its own enable, disable and reset controls.
// - Separate sleep and deep-sleep enable sets applied on mode entry.
// - Any oscillator may be chosen as the PLL reference.
// - Seven system events raise the processor interrupt.
// - Each interrupt source has its own enable.
// - Interrupt sources stay pending until software clears them.
// - Read-only registers report memory sizes, peripherals and pins.
// - LDO level setting from 2.25 V to 2.75 V, reset default 2.5 V.
// - Chosen peripherals may clock from the precision internal oscillator.
// - Internal oscillator serves as reference to detect main oscillator failure, and PLL failure while the run clock configuration selects the PLL.
// - Status reads raw or masked as software selects.
`timescale 1ns/1ps
module scrpc_top (
    input  wire logic                       clk,
    input  wire logic                       resetn,
    input  wire logic                       ce,
    input  wire logic [7:0]                 addr,
    input  wire logic [31:0]                wdata,
    input  wire logic                       wr,
    input  wire logic                       rd,
    output logic      [31:0]                rdata,
    input  wire logic                       sleep_req,
    input  wire logic                       deep_req,
    input  wire logic                       any_irq,
    input  wire logic [scrpc_pkg::NINT-1:0] irq_events,
    input  wire logic                       bor_evt,
    input  wire logic                       ldo_evt,
    input  wire logic                       ext_rst_n,
    input  wire logic                       wdt_evt,
    input  wire logic                       iosc_tick,
    input  wire logic                       mosc_tick,
    input  wire logic                       pll_tick,
    output logic                            core_clk_en,
    output logic [2:0]                      sys_clk_src,
    output logic [2:0]                      pll_ref_sel,
    output logic [scrpc_pkg::NPER-1:0]      per_clk_en,
    output logic [scrpc_pkg::NPER-1:0]      per_rst,
    output logic [scrpc_pkg::NPER-1:0]      per_precision_internal_osc_sel,
    output logic [3:0]                      ldo_level,
    output logic                            dev_rst,
    output logic                            sysctl_irq
);
    localparam logic [7:0] FD_LIMIT = 8'h40;

    logic [scrpc_pkg::NINT-1:0] ev_s;
    logic [3:0] pin_s;
    logic iosc_s, mosc_s, pll_s, ext_s;

    scrpc_sync #(.W(scrpc_pkg::NINT)) u_sync_ev (
        .clk(clk), .resetn(resetn), .ce(ce), .din(irq_events), .dout(ev_s));
    scrpc_sync #(.W(4)) u_sync_pin (
        .clk(clk), .resetn(resetn), .ce(ce),
        // The reset pin is inverted so that the flops' reset value equals its idle level.
        .din({iosc_tick, mosc_tick, pll_tick, ~ext_rst_n}),
        .dout(pin_s));
    assign iosc_s = pin_s[3];
    assign mosc_s = pin_s[2];
    assign pll_s  = pin_s[1];
    assign ext_s  = pin_s[0];

    scrpc_pkg::scrpc_clkcfg_type  clk_q, clk_d, dclk_q, dclk_d;
    scrpc_pkg::scrpc_mode_type    mode_q, mode_d;
    logic [scrpc_pkg::NPER-1:0]   en_q, en_d, slp_q, slp_d, dslp_q, dslp_d;
    logic [scrpc_pkg::NPER-1:0]   prst_q, prst_d, psel_q, psel_d, rdy_q, rdy_d;
    logic [scrpc_pkg::NINT-1:0]   ris_q, ris_d, imsk_q, imsk_d;
    logic [scrpc_pkg::NRST-1:0]   resc_q, resc_d, rcfg_q, rcfg_d;
    logic [3:0]                   ldo_q, ldo_d;
    logic [31:0]                  rdata_q, rdata_d;
    logic                         swr_q, swr_d, drst_q, drst_d, irq_q, irq_d;
    logic                         iosc_p_q, mosc_p_q, pll_p_q;
    logic [7:0]                   mcnt_q, mcnt_d, pcnt_q, pcnt_d;
    logic                         mfail_q, mfail_d, pfail_q, pfail_d;
    logic [scrpc_pkg::NPER-1:0]   pce_q, pce_d;
    logic                         cce_q, cce_d;
    logic [2:0]                   src_q, src_d;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        return a == b;
    endfunction

    function automatic logic [31:0] z32(input logic [scrpc_pkg::NPER-1:0] v);
        return {{(32-scrpc_pkg::NPER){1'b0}}, v};
    endfunction

    logic [scrpc_pkg::NINT-1:0] ev_all;
    logic [scrpc_pkg::NRST-1:0] rst_ev;
    logic iosc_rise, mosc_rise, pll_rise;

    always_comb begin
        iosc_rise = iosc_s & ~iosc_p_q;
        mosc_rise = mosc_s & ~mosc_p_q;
        pll_rise  = pll_s & ~pll_p_q;
        ev_all    = ev_s;
        ev_all[scrpc_pkg::I_MOSCF] = ev_s[scrpc_pkg::I_MOSCF] | mfail_q;
        ev_all[scrpc_pkg::I_PLLF]  = ev_s[scrpc_pkg::I_PLLF] | pfail_q;
        rst_ev = '0;
        rst_ev[scrpc_pkg::R_BOR]  = bor_evt;
        rst_ev[scrpc_pkg::R_LDO]  = ldo_evt;
        rst_ev[scrpc_pkg::R_EXT]  = ext_s;
        rst_ev[scrpc_pkg::R_SW]   = swr_q;
        rst_ev[scrpc_pkg::R_WDT]  = wdt_evt;
        rst_ev[scrpc_pkg::R_MOSC] = mfail_q;
    end

    always_comb begin
        clk_d  = clk_q;
        dclk_d = dclk_q;
        mode_d = mode_q;
        en_d   = en_q;
        slp_d  = slp_q;
        dslp_d = dslp_q;
        prst_d = prst_q;
        psel_d = psel_q;
        imsk_d = imsk_q;
        rcfg_d = rcfg_q;
        ldo_d  = ldo_q;
        swr_d  = 1'b0;
        ris_d  = ris_q;
        resc_d = resc_q;
        if (wr) begin
            if (hit(addr, scrpc_pkg::A_CLKCFG))   clk_d  = wdata[5:0];
            if (hit(addr, scrpc_pkg::A_DSCLKCFG)) dclk_d = wdata[5:0];
            if (hit(addr, scrpc_pkg::A_PERIPH))   en_d   = wdata[scrpc_pkg::NPER-1:0];
            if (hit(addr, scrpc_pkg::A_SLPEN))    slp_d  = wdata[scrpc_pkg::NPER-1:0];
            if (hit(addr, scrpc_pkg::A_DSLPEN))   dslp_d = wdata[scrpc_pkg::NPER-1:0];
            if (hit(addr, scrpc_pkg::A_PERRST))   prst_d = wdata[scrpc_pkg::NPER-1:0];
            if (hit(addr, scrpc_pkg::A_IMASK))    imsk_d = wdata[scrpc_pkg::NINT-1:0];
            if (hit(addr, scrpc_pkg::A_PIOSCSEL)) psel_d = wdata[scrpc_pkg::NPER-1:0];
            if (hit(addr, scrpc_pkg::A_RSTCFG))   rcfg_d = wdata[scrpc_pkg::NRST-1:0];
            if (hit(addr, scrpc_pkg::A_LDO) && wdata <= {28'h000_0000, scrpc_pkg::LDO_MAX})
                ldo_d = wdata[3:0];
            if (hit(addr, scrpc_pkg::A_SWRST) && wdata == scrpc_pkg::SWRST_KEY)
                swr_d = 1'b1;
            if (hit(addr, scrpc_pkg::A_RIS))
                ris_d = ris_q & ~wdata[scrpc_pkg::NINT-1:0];
            if (hit(addr, scrpc_pkg::A_RESC))
                resc_d = resc_q & ~wdata[scrpc_pkg::NRST-1:0];
            if (hit(addr, scrpc_pkg::A_MODE) && wdata[1:0] == 2'h0)
                mode_d = scrpc_pkg::SCRPC_RUN;
        end
        ris_d  = ris_d | ev_all;
        resc_d = resc_d | (rst_ev & rcfg_q);
        case (mode_q)
            scrpc_pkg::SCRPC_RUN: begin
                if (deep_req) mode_d = scrpc_pkg::SCRPC_DEEP;
                else if (sleep_req) mode_d = scrpc_pkg::SCRPC_SLEEP;
            end
            scrpc_pkg::SCRPC_SLEEP,
            scrpc_pkg::SCRPC_DEEP: begin
                if (any_irq || sysctl_irq) mode_d = scrpc_pkg::SCRPC_RUN;
            end
            default: mode_d = scrpc_pkg::SCRPC_RUN;
        endcase
    end

    // Failure detect: count internal oscillator ticks between monitored ticks.
    always_comb begin
        mcnt_d  = mcnt_q;
        pcnt_d  = pcnt_q;
        mfail_d = mfail_q;
        pfail_d = pfail_q;
        if (mosc_rise) mcnt_d = '0;
        else if (iosc_rise && mcnt_q != FD_LIMIT) mcnt_d = mcnt_q + 8'h01;
        if (pll_rise) pcnt_d = '0;
        else if (iosc_rise && pcnt_q != FD_LIMIT) pcnt_d = pcnt_q + 8'h01;
        mfail_d = (mcnt_q == FD_LIMIT);
        pfail_d = (pcnt_q == FD_LIMIT) && (clk_q.sys_src == scrpc_pkg::OSC_PLL);
    end

    always_comb begin
        cce_d = (mode_q == scrpc_pkg::SCRPC_RUN);
        src_d = clk_q.sys_src;
        if (mode_q == scrpc_pkg::SCRPC_DEEP) begin
            src_d = dclk_q.sys_src;
            if (src_d == scrpc_pkg::OSC_PLL) src_d = scrpc_pkg::OSC_MAIN;
        end
        case (mode_q)
            scrpc_pkg::SCRPC_SLEEP: pce_d = en_q & slp_q & ~prst_q;
            scrpc_pkg::SCRPC_DEEP:  pce_d = en_q & dslp_q & ~prst_q;
            default:                pce_d = en_q & ~prst_q;
        endcase
        rdy_d  = en_q & ~prst_q;
        drst_d = |rst_ev;
        irq_d  = |(ris_q & imsk_q);
        rdata_d = '0;
        if (rd) begin
            case (addr)
                scrpc_pkg::A_CLKCFG:   rdata_d = {26'h000_0000, clk_q};
                scrpc_pkg::A_DSCLKCFG: rdata_d = {26'h000_0000, dclk_q};
                scrpc_pkg::A_PERIPH:   rdata_d = z32(en_q);
                scrpc_pkg::A_SLPEN:    rdata_d = z32(slp_q);
                scrpc_pkg::A_DSLPEN:   rdata_d = z32(dslp_q);
                scrpc_pkg::A_PERRST:   rdata_d = z32(prst_q);
                scrpc_pkg::A_RIS:      rdata_d = {25'h000_0000, ris_q};
                scrpc_pkg::A_IMASK:    rdata_d = {25'h000_0000, imsk_q};
                scrpc_pkg::A_MIS:      rdata_d = {25'h000_0000, ris_q & imsk_q};
                scrpc_pkg::A_RESC:     rdata_d = {26'h000_0000, resc_q};
                scrpc_pkg::A_LDO:      rdata_d = {28'h000_0000, ldo_q};
                scrpc_pkg::A_MODE:     rdata_d = {30'h0000_0000, mode_q};
                scrpc_pkg::A_PRESENT:  rdata_d = z32(scrpc_pkg::PRESENT_DEF);
                scrpc_pkg::A_MEMSIZE:  rdata_d = scrpc_pkg::MEMSIZE_DEF;
                scrpc_pkg::A_PINS:     rdata_d = scrpc_pkg::PINS_DEF;
                scrpc_pkg::A_READY:    rdata_d = z32(rdy_q);
                scrpc_pkg::A_PIOSCSEL: rdata_d = z32(psel_q);
                scrpc_pkg::A_RSTCFG:   rdata_d = {26'h000_0000, rcfg_q};
                default:               rdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            clk_q    <= '0;
            dclk_q   <= '0;
            mode_q   <= scrpc_pkg::SCRPC_RUN;
            en_q     <= '0;
            slp_q    <= '0;
            dslp_q   <= '0;
            prst_q   <= '0;
            psel_q   <= '0;
            ris_q    <= '0;
            imsk_q   <= '0;
            resc_q   <= '0;
            rcfg_q   <= '1;
            ldo_q    <= scrpc_pkg::LDO_DEF;
            rdata_q  <= '0;
            swr_q    <= 1'b0;
            drst_q   <= 1'b0;
            irq_q    <= 1'b0;
            iosc_p_q <= 1'b0;
            mosc_p_q <= 1'b0;
            pll_p_q  <= 1'b0;
            mcnt_q   <= '0;
            pcnt_q   <= '0;
            mfail_q  <= 1'b0;
            pfail_q  <= 1'b0;
            pce_q    <= '0;
            rdy_q    <= '0;
            cce_q    <= 1'b0;
            src_q    <= scrpc_pkg::OSC_MAIN;
        end else if (ce) begin
            clk_q    <= clk_d;
            dclk_q   <= dclk_d;
            mode_q   <= mode_d;
            en_q     <= en_d;
            slp_q    <= slp_d;
            dslp_q   <= dslp_d;
            prst_q   <= prst_d;
            psel_q   <= psel_d;
            ris_q    <= ris_d;
            imsk_q   <= imsk_d;
            resc_q   <= resc_d;
            rcfg_q   <= rcfg_d;
            ldo_q    <= ldo_d;
            rdata_q  <= rdata_d;
            swr_q    <= swr_d;
            drst_q   <= drst_d;
            irq_q    <= irq_d;
            iosc_p_q <= iosc_s;
            mosc_p_q <= mosc_s;
            pll_p_q  <= pll_s;
            mcnt_q   <= mcnt_d;
            pcnt_q   <= pcnt_d;
            mfail_q  <= mfail_d;
            pfail_q  <= pfail_d;
            pce_q    <= pce_d;
            rdy_q    <= rdy_d;
            cce_q    <= cce_d;
            src_q    <= src_d;
        end
    end

    assign rdata         = rdata_q;
    assign core_clk_en   = cce_q;
    assign sys_clk_src   = src_q;
    assign pll_ref_sel   = clk_q.pll_ref;
    assign per_clk_en    = pce_q;
    assign per_rst       = prst_q;
    assign per_precision_internal_osc_sel = psel_q;
    assign ldo_level     = ldo_q;
    assign dev_rst       = drst_q;
    assign sysctl_irq    = irq_q;
endmodule // scrpc_top

// [verification/scrpc_chk.sv]
`timescale 1ns/1ps
module scrpc_chk (
    input wire logic                       clk,
    input wire logic                       resetn,
    input wire logic                       ce,
    input wire logic [7:0]                 addr,
    input wire logic [31:0]                wdata,
    input wire logic                       wr,
    input wire logic                       rd,
    input wire logic [31:0]                rdata,
    input wire logic                       sleep_req,
    input wire logic                       deep_req,
    input wire logic                       any_irq,
    input wire logic [scrpc_pkg::NINT-1:0] irq_events,
    input wire logic                       bor_evt,
    input wire logic                       ldo_evt,
    input wire logic                       ext_rst_n,
    input wire logic                       wdt_evt,
    input wire logic                       iosc_tick,
    input wire logic                       mosc_tick,
    input wire logic                       pll_tick,
    input wire logic                       core_clk_en,
    input wire logic [2:0]                 sys_clk_src,
    input wire logic [2:0]                 pll_ref_sel,
    input wire logic [scrpc_pkg::NPER-1:0] per_clk_en,
    input wire logic [scrpc_pkg::NPER-1:0] per_rst,
    input wire logic [scrpc_pkg::NPER-1:0] per_precision_internal_osc_sel,
    input wire logic [3:0]                 ldo_level,
    input wire logic                       dev_rst,
    input wire logic                       sysctl_irq
);
    logic deep_q;
    logic deep_d;
    // Remembers which sleep mode was last requested from run.
    always_comb begin
        deep_d = deep_q;
        if (core_clk_en && (deep_req || sleep_req)) begin
            deep_d = deep_req;
        end
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            deep_q <= 1'b0;
        end else begin
            deep_q <= deep_d;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    property p_sleep_core;
        sleep_req && core_clk_en && !any_irq && !sysctl_irq |-> ##[1:2] !core_clk_en;
    endproperty
    a_sleep_core: assert property (p_sleep_core)
        else $error("core clock not stopped on sleep request");
    property p_wake;
        !core_clk_en && any_irq |-> ##[1:2] core_clk_en;
    endproperty
    a_wake: assert property (p_wake)
        else $error("core not woken by interrupt");
    property p_stay_run;
        core_clk_en && !sleep_req && !deep_req && !$past(sleep_req) && !$past(deep_req)
            |=> core_clk_en;
    endproperty
    a_stay_run: assert property (p_stay_run)
        else $error("core stopped without request");
    property p_deep_src;
        deep_q && !core_clk_en && !$past(core_clk_en) |-> sys_clk_src != scrpc_pkg::OSC_PLL;
    endproperty
    a_deep_src: assert property (p_deep_src)
        else $error("deep sleep still on pll");
    property p_rst_evt;
        bor_evt || ldo_evt || wdt_evt |=> dev_rst;
    endproperty
    a_rst_evt: assert property (p_rst_evt)
        else $error("reset event gave no device reset");
    property p_irq_hold;
        sysctl_irq && !wr && !$past(wr) |=> sysctl_irq;
    endproperty
    a_irq_hold: assert property (p_irq_hold)
        else $error("interrupt dropped without a write");
    property p_info;
        $past(rd) && $past(addr) == scrpc_pkg::A_PRESENT
            |-> rdata == {24'h00_0000, scrpc_pkg::PRESENT_DEF};
    endproperty
    a_info: assert property (p_info)
        else $error("present register wrong");
    property p_gate;
        (per_clk_en & per_rst & $past(per_rst)) == 8'h00;
    endproperty
    a_gate: assert property (p_gate)
        else $error("peripheral clocked while in reset");
    property p_ldo;
        wr && addr == scrpc_pkg::A_LDO && wdata > 32'h0000_000A
            |=> $stable(ldo_level) ##1 $stable(ldo_level);
    endproperty
    a_ldo: assert property (p_ldo)
        else $error("out of range level accepted");
endmodule // scrpc_chk

// [verification/scrpc_core_model.sv]
`timescale 1ns/1ps
module scrpc_core_model (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        core_clk_en,
    input  wire logic        sysctl_irq,
    input  wire logic        ext_irq,
    output logic             any_irq,
    output logic [15:0]      retired
);
    // The core folds every interrupt line into one wake request.
    assign any_irq = sysctl_irq | ext_irq;
    // Instructions retire only while the core is clocked.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            retired <= 16'h0000;
        end else if (core_clk_en) begin
            retired <= retired + 16'h0001;
        end
    end
endmodule // scrpc_core_model

// [verification/test_system_clock_reset_power_control.sv]
`timescale 1ns/1ps
module test_system_clock_reset_power_control;
    logic clk = 1'b0, resetn = 1'b0, ce = 1'b1, wr = 1'b0, rd = 1'b0;
    logic sleep_req = 1'b0, deep_req = 1'b0, ext_irq = 1'b0, bor_evt = 1'b0;
    logic ldo_evt = 1'b0, wdt_evt = 1'b0, ext_rst_n = 1'b1, stop_mosc = 1'b0;
    logic iosc_tick = 1'b0, mosc_tick = 1'b0, pll_tick = 1'b0, any_irq;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000, rdata;
    logic [6:0] irq_events = 7'h00;
    logic [2:0] tcnt = 3'h0, sys_clk_src, pll_ref_sel;
    logic [7:0] per_clk_en, per_rst, per_precision_internal_osc_sel;
    logic [3:0] ldo_level;
    logic core_clk_en, dev_rst, sysctl_irq;
    logic [15:0] retired, r;
    int mismatches = 0, cmp_count = 0, cyc = 0;
    always #2.5 clk = ~clk;
    scrpc_top i_dut (.clk(clk), .resetn(resetn), .ce(ce), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .sleep_req(sleep_req), .deep_req(deep_req),
        .any_irq(any_irq), .irq_events(irq_events), .bor_evt(bor_evt), .ldo_evt(ldo_evt),
        .ext_rst_n(ext_rst_n), .wdt_evt(wdt_evt), .iosc_tick(iosc_tick),
        .mosc_tick(mosc_tick), .pll_tick(pll_tick), .core_clk_en(core_clk_en),
        .sys_clk_src(sys_clk_src), .pll_ref_sel(pll_ref_sel), .per_clk_en(per_clk_en),
        .per_rst(per_rst), .per_precision_internal_osc_sel(per_precision_internal_osc_sel), .ldo_level(ldo_level),
        .dev_rst(dev_rst), .sysctl_irq(sysctl_irq));
    scrpc_core_model i_core (.clk(clk), .resetn(resetn), .core_clk_en(core_clk_en),
        .sysctl_irq(sysctl_irq), .ext_irq(ext_irq), .any_irq(any_irq), .retired(retired));
    // Internal oscillator ticks every 8 cycles, main oscillator and pll every 2.
    always @(posedge clk) begin
        tcnt <= tcnt + 3'h1;
        iosc_tick <= tcnt[2];
        pll_tick <= tcnt[0];
        if (!stop_mosc) begin
            mosc_tick <= tcnt[0];
        end
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            mismatches++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        $display("mismatches=%0d comparisons=%0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk($sformatf("rdata_%h", a), e, rdata);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        rd_chk(scrpc_pkg::A_LDO, {28'h000_0000, scrpc_pkg::LDO_DEF});
        rd_chk(scrpc_pkg::A_RESC, 32'h0000_0000);
        wr_reg(scrpc_pkg::A_PRESENT, 32'h0000_0000);
        rd_chk(scrpc_pkg::A_PRESENT, {24'h00_0000, scrpc_pkg::PRESENT_DEF});
        rd_chk(scrpc_pkg::A_MEMSIZE, scrpc_pkg::MEMSIZE_DEF);
        rd_chk(scrpc_pkg::A_PINS, scrpc_pkg::PINS_DEF);
        rd_chk(8'h4C, 32'h0000_0000);
        wr_reg(scrpc_pkg::A_LDO, 32'h0000_000A);
        wr_reg(scrpc_pkg::A_LDO, 32'h0000_000B);
        wr_reg(scrpc_pkg::A_LDO, 32'h0000_0015);
        ce <= 1'b0;
        wr_reg(scrpc_pkg::A_LDO, 32'h0000_0000);
        ce <= 1'b1;
        tick(2);
        chk("ldo_level", {28'h000_0000, scrpc_pkg::LDO_MAX}, {28'h000_0000, ldo_level});
        for (int i = 0; i <= 4; i++) begin
            wr_reg(scrpc_pkg::A_CLKCFG, 32'(i) << 3);
            tick(2);
            chk("pll_ref_sel", 32'(i), {29'h0000_0000, pll_ref_sel});
        end
        wr_reg(scrpc_pkg::A_PERIPH, 32'h0000_00A5);
        wr_reg(scrpc_pkg::A_PERRST, 32'h0000_0005);
        wr_reg(scrpc_pkg::A_PIOSCSEL, 32'h0000_0081);
        tick(2);
        chk("per_clk_en", 32'h0000_00A0, {24'h00_0000, per_clk_en});
        chk("per_rst", 32'h0000_0005, {24'h00_0000, per_rst});
        chk("per_precision_internal_osc_sel", 32'h0000_0081, {24'h00_0000, per_precision_internal_osc_sel});
        rd_chk(scrpc_pkg::A_READY, 32'h0000_00A0);
        wr_reg(scrpc_pkg::A_PERRST, 32'h0000_0000);
        wr_reg(scrpc_pkg::A_SLPEN, 32'h0000_0005);
        wr_reg(scrpc_pkg::A_DSLPEN, 32'h0000_0020);
        wr_reg(scrpc_pkg::A_CLKCFG, {29'h0000_0000, scrpc_pkg::OSC_PLL});
        tick(2);
        chk("per_clk_en", 32'h0000_00A5, {24'h00_0000, per_clk_en});
        @(posedge clk) sleep_req <= 1'b1;
        @(posedge clk) sleep_req <= 1'b0;
        tick(3);
        r = retired;
        chk("core_clk_en", 32'h0000_0000, {31'h0000_0000, core_clk_en});
        chk("per_clk_en", 32'h0000_0005, {24'h00_0000, per_clk_en});
        chk("sys_clk_src", 32'h0000_0004, {29'h0000_0000, sys_clk_src});
        tick(3);
        chk("retired", {16'h0000, r}, {16'h0000, retired});
        @(posedge clk) ext_irq <= 1'b1;
        @(posedge clk) ext_irq <= 1'b0;
        tick(3);
        chk("core_clk_en", 32'h0000_0001, {31'h0000_0000, core_clk_en});
        wr_reg(scrpc_pkg::A_IMASK, 32'h0000_0001);
        @(posedge clk) deep_req <= 1'b1;
        @(posedge clk) deep_req <= 1'b0;
        tick(3);
        chk("core_clk_en", 32'h0000_0000, {31'h0000_0000, core_clk_en});
        chk("sys_clk_src", 32'h0000_0000, {29'h0000_0000, sys_clk_src});
        chk("per_clk_en", 32'h0000_0020, {24'h00_0000, per_clk_en});
        rd_chk(scrpc_pkg::A_MODE, 32'(scrpc_pkg::SCRPC_DEEP));
        @(posedge clk) irq_events <= 7'h01;
        for (int k = 0; k < 20 && core_clk_en !== 1'b1; k++) @(posedge clk);
        irq_events <= 7'h00;
        tick(2);
        chk("core_clk_en", 32'h0000_0001, {31'h0000_0000, core_clk_en});
        chk("sys_clk_src", 32'h0000_0004, {29'h0000_0000, sys_clk_src});
        wr_reg(scrpc_pkg::A_RIS, 32'h0000_0001);
        wr_reg(scrpc_pkg::A_CLKCFG, 32'h0000_0000);
        @(posedge clk) irq_events <= 7'h7F;
        repeat (4) @(posedge clk);
        irq_events <= 7'h00;
        tick(3);
        rd_chk(scrpc_pkg::A_RIS, 32'h0000_007F);
        rd_chk(scrpc_pkg::A_MIS, 32'h0000_0001);
        chk("sysctl_irq", 32'h0000_0001, {31'h0000_0000, sysctl_irq});
        wr_reg(scrpc_pkg::A_RIS, 32'h0000_0001);
        tick(2);
        chk("sysctl_irq", 32'h0000_0000, {31'h0000_0000, sysctl_irq});
        rd_chk(scrpc_pkg::A_RIS, 32'h0000_007E);
        wr_reg(scrpc_pkg::A_RIS, 32'h0000_007E);
        wr_reg(scrpc_pkg::A_RSTCFG, 32'h0000_003E);
        wr_reg(scrpc_pkg::A_RESC, 32'h0000_003F);
        @(posedge clk) bor_evt <= 1'b1;
        @(posedge clk) bor_evt <= 1'b0;
        ldo_evt <= 1'b1;
        @(posedge clk) ldo_evt <= 1'b0;
        wdt_evt <= 1'b1;
        @(posedge clk) wdt_evt <= 1'b0;
        ext_rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        ext_rst_n <= 1'b1;
        wr_reg(scrpc_pkg::A_SWRST, 32'h0000_0002);
        tick(3);
        rd_chk(scrpc_pkg::A_RESC, 32'h0000_0016);
        wr_reg(scrpc_pkg::A_SWRST, scrpc_pkg::SWRST_KEY);
        tick(3);
        rd_chk(scrpc_pkg::A_RESC, 32'h0000_001E);
        wr_reg(scrpc_pkg::A_RESC, 32'h0000_0002);
        rd_chk(scrpc_pkg::A_RESC, 32'h0000_001C);
        wr_reg(scrpc_pkg::A_RESC, 32'h0000_003F);
        wr_reg(scrpc_pkg::A_IMASK, 32'h0000_0008);
        stop_mosc <= 1'b1;
        for (int k = 0; k < 1500 && sysctl_irq !== 1'b1; k++) @(posedge clk);
        tick(3);
        rd_chk(scrpc_pkg::A_RIS, 32'h0000_0008);
        rd_chk(scrpc_pkg::A_RESC, 32'h0000_0020);
        report_and_stop();
    end
endmodule // test_system_clock_reset_power_control
bind scrpc_top scrpc_chk i_chk (.*);
